// ===== design/csw_clock_switch.sv
// System clock switch, sleep pin control and power-up delay sequencer
//
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module csw_clock_switch #(
  parameter int unsigned POWER_UP_DELAY_TIMER_CYC = csw_pkg::POWER_UP_DELAY_TIMER_CYCLES,
  parameter int unsigned PLL_CYC = csw_pkg::PLL_CYCLES
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Configuration and secondary timer control
  input wire logic [2:0] main_osc_mode_config,
  input wire logic clock_switch_enable_config,
  input wire logic power_up_delay_timer_enable_config,
  input wire logic secondary_osc_enable,
  // Oscillator and detector pins
  input wire logic osc_input_pin,
  input wire logic secondary_osc_pin,
  input wire logic brownout_reset,
  // Wake and reset events, same clock
  input wire logic ext_reset,
  input wire logic wdt_reset,
  input wire logic wake_irq,
  // Output pin and port function
  input wire logic osc_output_pin_i,
  output logic osc_output_pin_o,
  output logic osc_output_pin_oe_n,
  input wire logic port_a_bit6_out,
  input wire logic port_a_bit6_oe_n,
  output logic port_a_bit6_in,
  // Clock and core control
  output logic sys_clk,
  output logic first_quarter_phase,
  output logic cpu_stall,
  output logic hold_in_reset,
  output logic sleeping,
  output logic osc_enable,
  output logic feedback_inverter_enable,
  output logic multiplier_enable
);

  localparam logic [csw_pkg::CNT_W-1:0] POWER_UP_DELAY_TIMER_LAST = csw_pkg::CNT_W'(POWER_UP_DELAY_TIMER_CYC - 1);
  localparam logic [csw_pkg::CNT_W-1:0] PLL_LAST = csw_pkg::CNT_W'(PLL_CYC - 1);

  typedef struct packed {
    csw_pkg::csw_state_e st;
    logic released;
    logic switching;
    logic tgt;
    logic clock_source_select;
    logic src_active;
    logic sleep_pend;
    logic [csw_pkg::CNT_W-1:0] cnt;
    logic [1:0] q_phase;
    logic sys_clk;
    logic osc_out;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } csw_state_s;

  csw_state_s st;
  csw_state_s next_st;
  csw_osc_if osc ();
  csw_pkg::csw_mode_e mode;
  logic allowed;
  logic crystal;
  logic hspll;
  logic io_mode;
  logic act_rise;
  logic act_lvl;
  logic tgt_rise;
  logic any_reset;
  logic do_wr;
  logic [7:0] status;

  // Oscillator, brown-out and pin levels cross into aclk here
  csw_pin_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pins({brownout_reset, osc_output_pin_i, secondary_osc_pin, osc_input_pin}),
    .osc(osc.sync)
  );

  // Mode decode and source selection
  always_comb begin
    mode = csw_pkg::csw_mode_e'(main_osc_mode_config);
    crystal = (mode == csw_pkg::M_LP) || (mode == csw_pkg::M_XT) ||
              (mode == csw_pkg::M_HS) || (mode == csw_pkg::M_HSPLL);
    hspll = (mode == csw_pkg::M_HSPLL);
    io_mode = (mode == csw_pkg::M_RESISTOR_CAP_IO_MODE) || (mode == csw_pkg::M_EXTERNAL_CLOCK_IO_MODE);
    allowed = !clock_switch_enable_config && secondary_osc_enable;
    // active source picks the edge stream
    act_rise = st.src_active ? osc.rise[csw_pkg::LN_SEC] : osc.rise[csw_pkg::LN_MAIN];
    act_lvl = st.src_active ? osc.lvl[csw_pkg::LN_SEC] : osc.lvl[csw_pkg::LN_MAIN];
    tgt_rise = st.tgt ? osc.rise[csw_pkg::LN_SEC] : osc.rise[csw_pkg::LN_MAIN];
    any_reset = ext_reset || wdt_reset;
    do_wr = st.aw_held && st.w_held && !st.bvalid;
  end

  // Status word seen by software
  always_comb begin
    status = 8'h00;
    status[csw_pkg::ST_SRC_BIT] = st.src_active;
    status[csw_pkg::ST_STALL_BIT] = cpu_stall;
    status[csw_pkg::ST_HOLD_BIT] = !st.released;
    status[csw_pkg::ST_SLEEP_BIT] = sleeping;
    status[csw_pkg::ST_MULT_BIT] = multiplier_enable;
  end

  // Next state: bus slave, select bit and sequencer
  always_comb begin
    next_st = st;
    // Write channels are latched independently, in either order
    if (awvalid && awready) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_st.w_held = 1'b1;
      next_st.w_data = wdata;
      next_st.w_strb = wstrb;
    end
    if (st.bvalid && bready) begin
      next_st.bvalid = 1'b0;
    end
    if (do_wr) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = csw_pkg::RESP_OKAY;
      case (st.aw_addr)
        csw_pkg::OSC_SEL_ADDR: begin
          if (st.w_strb[0]) begin
            next_st.clock_source_select = st.w_data[csw_pkg::SCS_BIT] && allowed;
          end
        end
        csw_pkg::CONTROL_ADDR: begin
          if (st.w_strb[0] && st.w_data[csw_pkg::CTL_SLEEP_BIT]) begin
            next_st.sleep_pend = 1'b1;
          end
        end
        csw_pkg::STATUS_ADDR: begin
          next_st.bresp = csw_pkg::RESP_OKAY;
        end
        default: begin
          next_st.bresp = csw_pkg::RESP_SLVERR;
        end
      endcase
    end
    // Read answers one cycle after the address is taken
    if (st.rvalid && rready) begin
      next_st.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = csw_pkg::RESP_OKAY;
      case (araddr)
        csw_pkg::OSC_SEL_ADDR: next_st.rdata = {31'h00000000, st.clock_source_select};
        csw_pkg::STATUS_ADDR: next_st.rdata = {24'h000000, status};
        csw_pkg::CONTROL_ADDR: next_st.rdata = {31'h00000000, st.sleep_pend};
        default: begin
          next_st.rdata = 32'h00000000;
          next_st.rresp = csw_pkg::RESP_SLVERR;
        end
      endcase
    end
    // bit forced clear when switching not permitted
    if (!allowed) begin
      next_st.clock_source_select = 1'b0;
    end
    // Quarter phase runs off the active source while running
    if (st.st == csw_pkg::S_RUN && act_rise) begin
      next_st.q_phase = st.q_phase + 2'h1;
    end
    case (st.st)
      csw_pkg::S_POWER_UP_DELAY_TIMER: begin
        next_st.cnt = st.cnt + 24'h000001;
        if (!power_up_delay_timer_enable_config || st.cnt >= POWER_UP_DELAY_TIMER_LAST) begin
          next_st.cnt = '0;
          next_st.st = crystal ? csw_pkg::S_OST : csw_pkg::S_RUN;
          next_st.released = !crystal;
        end
      end
      csw_pkg::S_OST: begin
        if (osc.rise[csw_pkg::LN_MAIN]) begin
          next_st.cnt = st.cnt + 24'h000001;
          if (st.cnt == csw_pkg::OST_LAST) begin
            next_st.cnt = '0;
            if (hspll) begin
              next_st.st = csw_pkg::S_PLL;
            end else begin
              next_st.st = st.switching ? csw_pkg::S_SYNC : csw_pkg::S_RUN;
              next_st.released = 1'b1;
            end
          end
        end
      end
      csw_pkg::S_PLL: begin
        next_st.cnt = st.cnt + 24'h000001;
        if (st.cnt >= PLL_LAST) begin
          next_st.cnt = '0;
          next_st.st = st.switching ? csw_pkg::S_SYNC : csw_pkg::S_RUN;
          next_st.released = 1'b1;
        end
      end
      csw_pkg::S_RUN: begin
        if (st.sleep_pend && st.q_phase == 2'h0) begin
          next_st.st = csw_pkg::S_SLEEP;
          next_st.sleep_pend = 1'b0;
        end else if (st.clock_source_select != st.src_active && st.q_phase == 2'h0) begin
          // target latched; edges counted only from here on
          next_st.switching = 1'b1;
          next_st.tgt = st.clock_source_select;
          next_st.cnt = '0;
          // crystal return needs start-up; others do not
          next_st.st = (!st.clock_source_select && crystal) ? csw_pkg::S_OST : csw_pkg::S_SYNC;
        end
      end
      csw_pkg::S_SYNC: begin
        // eight rising edges of the incoming source
        if (tgt_rise) begin
          next_st.cnt = st.cnt + 24'h000001;
          if (st.cnt == csw_pkg::EDGE_LAST) begin
            next_st.cnt = '0;
            next_st.src_active = st.tgt;
            next_st.switching = 1'b0;
            next_st.q_phase = 2'h0;
            next_st.st = csw_pkg::S_RUN;
          end
        end
      end
      csw_pkg::S_SLEEP: begin
        if (any_reset || wake_irq) begin
          next_st.cnt = '0;
          // start-up on wake only for crystal main source
          next_st.st = (crystal && !st.src_active) ? csw_pkg::S_OST : csw_pkg::S_RUN;
        end
      end
      default: begin
        next_st.st = csw_pkg::S_POWER_UP_DELAY_TIMER;
        next_st.cnt = '0;
      end
    endcase
    // resets clear the select bit; they return to main only once released and not in sleep
    if (any_reset && st.st != csw_pkg::S_SLEEP && st.released) begin
      next_st.clock_source_select = 1'b0;
      next_st.src_active = 1'b0;
      next_st.switching = 1'b0;
      next_st.sleep_pend = 1'b0;
      next_st.cnt = '0;
      next_st.q_phase = 2'h0;
      next_st.st = csw_pkg::S_RUN;
    end else if (any_reset) begin
      next_st.clock_source_select = 1'b0;
      next_st.sleep_pend = 1'b0;
    end
    if (osc.lvl[csw_pkg::LN_BOR]) begin
      next_st.st = csw_pkg::S_POWER_UP_DELAY_TIMER;
      next_st.cnt = '0;
      next_st.released = 1'b0;
      next_st.clock_source_select = 1'b0;
      next_st.src_active = 1'b0;
      next_st.switching = 1'b0;
      next_st.sleep_pend = 1'b0;
    end
    // gated clock only follows the source while running
    next_st.sys_clk = (next_st.st == csw_pkg::S_RUN && st.st == csw_pkg::S_RUN) ?
                      act_lvl : st.sys_clk;
    // clock/4 in RC and external modes, low in sleep
    next_st.osc_out = (next_st.st != csw_pkg::S_SLEEP) && next_st.q_phase[1];
  end

  // Single state register; all-zero is the power-on state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Bus handshakes; one write and one read in flight
  assign awready = !st.aw_held && !st.bvalid;
  assign wready = !st.w_held && !st.bvalid;
  assign bvalid = st.bvalid;
  assign bresp = st.bresp;
  assign arready = !st.rvalid;
  assign rvalid = st.rvalid;
  assign rdata = st.rdata;
  assign rresp = st.rresp;

  // Core clock and control outputs
  assign sys_clk = st.sys_clk;
  assign first_quarter_phase = (st.st == csw_pkg::S_RUN) && (st.q_phase == 2'h0);
  assign cpu_stall = st.released && (st.st != csw_pkg::S_RUN) && (st.st != csw_pkg::S_SLEEP);
  assign hold_in_reset = !st.released;
  assign sleeping = (st.st == csw_pkg::S_SLEEP);
  assign osc_enable = !sleeping;
  // feedback inverter only for crystals, off in sleep
  assign feedback_inverter_enable = crystal && !sleeping;
  assign multiplier_enable = hspll && !sleeping;

  // Output pin: port in I/O modes, clock/4 in RC/EC, analog for crystals
  // port function kept in I/O variants
  assign osc_output_pin_o = io_mode ? port_a_bit6_out : (!crystal && st.osc_out);
  assign osc_output_pin_oe_n = io_mode ? port_a_bit6_oe_n : crystal;
  assign port_a_bit6_in = osc.lvl[csw_pkg::LN_OSCOUT];

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_scs_forced: assert property (!allowed |=> !st.clock_source_select)
    else $error("select bit set while switching not permitted");
  a_scs_ignored: assert property (do_wr && st.aw_addr == csw_pkg::OSC_SEL_ADDR && !allowed
    |=> !st.clock_source_select)
    else $error("select write took effect without permission");
  a_reset_clear: assert property (any_reset |=> !st.clock_source_select)
    else $error("select bit survived a reset");
  a_edge_count: assert property (st.st == csw_pkg::S_SYNC && next_st.st == csw_pkg::S_RUN
    && !any_reset && !osc.lvl[csw_pkg::LN_BOR] |-> st.cnt == 24'h000007 && tgt_rise)
    else $error("switch completed before eight edges");
  a_source_change: assert property ($changed(st.src_active) && !$past(any_reset)
    && !$past(osc.lvl[csw_pkg::LN_BOR]) |-> $past(st.st) == csw_pkg::S_SYNC)
    else $error("source changed outside the sync count");
  a_clk_still: assert property (cpu_stall |=> $stable(st.sys_clk))
    else $error("gated clock moved while frozen");
  a_sleep_off: assert property (sleeping |-> !osc_enable && !feedback_inverter_enable
    && !multiplier_enable)
    else $error("clocks running in sleep");
  a_pin_low: assert property (sleeping && !io_mode && !crystal
    |-> !osc_output_pin_o && !osc_output_pin_oe_n)
    else $error("output pin not held low in sleep");
  a_wake_exit: assert property (sleeping && (wake_irq || any_reset)
    && !osc.lvl[csw_pkg::LN_BOR] |=> !sleeping)
    else $error("missed a wake event");
  a_ost_length: assert property (st.st == csw_pkg::S_OST && next_st.st != csw_pkg::S_OST
    && !osc.lvl[csw_pkg::LN_BOR] && !any_reset |-> st.cnt == 24'h0003ff)
    else $error("start-up count not 1024 edges");
  a_mult_mode: assert property (multiplier_enable |-> mode == csw_pkg::M_HSPLL)
    else $error("multiplier on outside high-speed mode");
  a_bor_power_up_delay_timer: assert property (osc.lvl[csw_pkg::LN_BOR]
    |=> st.st == csw_pkg::S_POWER_UP_DELAY_TIMER && hold_in_reset)
    else $error("brown-out did not restart power-up delay");

endmodule // csw_clock_switch
`default_nettype wire

// ===== design/csw_osc_if.sv
// Synchronised oscillator and pin levels with rising-edge pulses
`timescale 1ns/10ps
`default_nettype none
interface csw_osc_if;
  logic [3:0] lvl;
  logic [3:0] rise;
  modport sync (output lvl, output rise);
  modport core (input lvl, input rise);
endinterface
`default_nettype wire

// ===== design/csw_pin_sync.sv
// Two-stage pin synchroniser with rising-edge detect per lane
`timescale 1ns/10ps
`default_nettype none
module csw_pin_sync (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Raw pins
  input wire logic [3:0] pins,
  // Synchronised view
  csw_osc_if.sync osc
);

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
  } csw_sync_s;

  csw_sync_s st;
  csw_sync_s next_st;

  // Shift chain; first stage only feeds the second
  always_comb begin
    next_st = st;
    next_st.s1 = pins;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign osc.lvl = st.s2;

  // Edge detect per lane from settled stages
  for (genvar i = 0; i < csw_pkg::LANES; i++) begin : g_lane
    assign osc.rise[i] = st.s2[i] & ~st.s3[i];
  end

endmodule // csw_pin_sync
`default_nettype wire

// ===== design/csw_pkg.sv
// Constants and types for the system clock switch and power-up sequencer
package csw_pkg;

  // Register byte addresses
  localparam logic [7:0] OSC_SEL_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] CONTROL_ADDR = 8'h08;
  localparam logic [7:0] OSC_SEL_RESET = 8'h00;

  // Field positions
  localparam int SCS_BIT = 0;
  localparam int CTL_SLEEP_BIT = 0;
  localparam int ST_SRC_BIT = 0;
  localparam int ST_STALL_BIT = 1;
  localparam int ST_HOLD_BIT = 2;
  localparam int ST_SLEEP_BIT = 3;
  localparam int ST_MULT_BIT = 4;

  // Pin synchroniser lanes
  localparam int LN_MAIN = 0;
  localparam int LN_SEC = 1;
  localparam int LN_OSCOUT = 2;
  localparam int LN_BOR = 3;
  localparam int LANES = 4;

  // Timing
  localparam int CNT_W = 24;
  localparam int CLK_PERIOD_NS = 5;
  localparam int POWER_UP_DELAY_TIMER_TIME_MS = 72;
  localparam int PLL_TIME_MS = 2;
  localparam int POWER_UP_DELAY_TIMER_CYCLES = POWER_UP_DELAY_TIMER_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int PLL_CYCLES = PLL_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] EDGE_LAST = 24'h000007;
  localparam logic [CNT_W-1:0] OST_LAST = 24'h0003ff;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Main oscillator mode configuration
  typedef enum logic [2:0] {
    M_LP = 3'h0, M_XT = 3'h1, M_HS = 3'h2, M_RC = 3'h3,
    M_EC = 3'h4, M_EXTERNAL_CLOCK_IO_MODE = 3'h5, M_HSPLL = 3'h6, M_RESISTOR_CAP_IO_MODE = 3'h7
  } csw_mode_e;

  // Sequencer states, Gray along the HSPLL power-up path and the RUN/SYNC switch path
  typedef enum logic [2:0] {
    S_POWER_UP_DELAY_TIMER = 3'h0, S_OST = 3'h1, S_PLL = 3'h3, S_RUN = 3'h2,
    S_SYNC = 3'h6, S_SLEEP = 3'h7
  } csw_state_e;

endpackage

// ===== tb/csw_clock_switch_tb.sv
// Self-checking bench for the clock switch and power-up sequencer
`timescale 1ns/10ps
`default_nettype none
module csw_clock_switch_tb;
  localparam int PW = 40;
  localparam int PL = 20;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [2:0] mode = 3'h3;
  logic sw_en_n = 1'b0, power_up_delay_timer_en = 1'b1, sec_en = 1'b1, bor = 1'b0;
  logic ext_rst = 1'b0, wdt_rst = 1'b0, irq = 1'b0, pa_out = 1'b0, pa_oe_n = 1'b1;
  logic main_pin, sec_pin, pin_o, pin_oe_n, pin_lvl, pa_in;
  logic sys_clk, fq, stall, hold, slp, osc_en, fb_en, mult_en;
  logic stall_d = 1'b0, clk_d = 1'b0;
  logic [1:0] r;
  int fail_count = 0, checked = 0, main_r = 0, sec_r = 0, moved = 0, n, rs, r0;

  // 200 MHz clock
  always #2.5 aclk = ~aclk;
  // Pull-up on the shared output pin when nobody drives it
  assign pin_lvl = pin_oe_n ? 1'b1 : pin_o;
  // Raw oscillator rise counters
  always @(posedge main_pin) main_r++;
  always @(posedge sec_pin) sec_r++;
  // Any sys_clk movement inside a stall is a glitch
  always @(posedge aclk) begin
    if (stall && stall_d && sys_clk !== clk_d) moved++;
    stall_d <= stall;
    clk_d <= sys_clk;
  end

  csw_osc_model OSC (.en(osc_en), .main_pin(main_pin), .sec_pin(sec_pin));

  csw_clock_switch #(.POWER_UP_DELAY_TIMER_CYC(PW), .PLL_CYC(PL)) DUT (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .main_osc_mode_config(mode), .clock_switch_enable_config(sw_en_n),
    .power_up_delay_timer_enable_config(power_up_delay_timer_en), .secondary_osc_enable(sec_en),
    .osc_input_pin(main_pin), .secondary_osc_pin(sec_pin), .brownout_reset(bor),
    .ext_reset(ext_rst), .wdt_reset(wdt_rst), .wake_irq(irq), .osc_output_pin_i(pin_lvl),
    .osc_output_pin_o(pin_o), .osc_output_pin_oe_n(pin_oe_n), .port_a_bit6_out(pa_out),
    .port_a_bit6_oe_n(pa_oe_n), .port_a_bit6_in(pa_in), .sys_clk(sys_clk),
    .first_quarter_phase(fq), .cpu_stall(stall), .hold_in_reset(hold), .sleeping(slp),
    .osc_enable(osc_en), .feedback_inverter_enable(fb_en), .multiplier_enable(mult_en));

  task automatic close_out;
    if (fail_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rng(input int v, input int lo, input int hi);
    checked++;
    if (v < lo || v > hi) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h..%h", $time, v, lo, hi);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask

  function automatic logic sel(input int k);
    case (k)
      0: return stall;
      1: return hold;
      default: return slp;
    endcase
  endfunction

  // Bounded wait on stall, hold or sleep
  task automatic wt(input int k, input logic v, input int lim, output int c);
    c = 0;
    while (sel(k) !== v && c < lim) begin
      @(posedge aclk);
      c++;
    end
    chk({31'h0, sel(k)}, {31'h0, v});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rp);
    int k;
    k = 0;
    rp = 2'h3;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // Wait up to 99 cycles for the response, then give up with rp left at 3
    while (k != 99) begin
      @(posedge aclk);
      k++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) begin
        rp = bresp;
        bready <= 1'b0;
        k = 99;
      end
    end
    @(posedge aclk);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int k;
    logic [31:0] d;
    logic [1:0] rp;
    k = 0;
    d = 32'hffffffff;
    rp = 2'h3;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    // Wait up to 99 cycles for the read data
    while (k != 99) begin
      @(posedge aclk);
      k++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) begin
        d = rdata;
        rp = rresp;
        rready <= 1'b0;
        k = 99;
      end
    end
    @(posedge aclk);
    chk(d, e);
    chk({30'h0, rp}, {30'h0, er});
  endtask

  // Full power-up; c is cycles in hold, rc the main rises seen meanwhile
  task automatic pwr(input logic [2:0] m, input logic pe, output int c, output int rc);
    int q;
    mode <= m;
    power_up_delay_timer_en <= pe;
    aresetn <= 1'b0;
    cyc(8);
    aresetn <= 1'b1;
    q = main_r;
    wt(1, 1'b0, 20000, c);
    rc = main_r - q;
  endtask

  // Source switch; rc counts raw rises of the target during the stall
  task automatic sw(input logic to_sec, output int rc, output int c);
    int q, k;
    logic [1:0] rp;
    moved = 0;
    wr(csw_pkg::OSC_SEL_ADDR, {31'h0, to_sec}, rp);
    wt(0, 1'b1, 200, k);
    q = to_sec ? sec_r : main_r;
    wt(0, 1'b0, 20000, c);
    rc = (to_sec ? sec_r : main_r) - q;
    chk(moved, 0);
  endtask

  task automatic pulse(input int k);
    ext_rst <= (k == 0);
    wdt_rst <= (k == 1);
    irq <= (k == 2);
    cyc(1);
    ext_rst <= 1'b0;
    wdt_rst <= 1'b0;
    irq <= 1'b0;
  endtask

  // Watchdog against a hung sequence
  initial begin
    #400000;
    fail_count++;
    close_out;
  end

  initial begin
    cyc(8);
    // Mode-dependent outputs, checked while still in reset
    for (int m = 0; m < 8; m++) begin
      mode <= 3'(m);
      cyc(2);
      chk({31'h0, mult_en}, {31'h0, m == 6});
      chk({31'h0, pin_oe_n}, {31'h0, m != 3 && m != 4});
    end
    pwr(3'h3, 1'b1, n, rs);
    rng(n, PW, PW + 8);
    rchk(csw_pkg::OSC_SEL_ADDR, 32'h0, csw_pkg::RESP_OKAY);
    pwr(3'h3, 1'b0, n, rs);
    rng(n, 0, 8);
    // Select writes must bounce unless both enables allow them
    sec_en <= 1'b0;
    wr(csw_pkg::OSC_SEL_ADDR, 32'h1, r);
    rchk(csw_pkg::OSC_SEL_ADDR, 32'h0, csw_pkg::RESP_OKAY);
    sec_en <= 1'b1;
    sw_en_n <= 1'b1;
    wr(csw_pkg::OSC_SEL_ADDR, 32'h1, r);
    rchk(csw_pkg::OSC_SEL_ADDR, 32'h0, csw_pkg::RESP_OKAY);
    sw_en_n <= 1'b0;
    wr(8'h0c, 32'h1, r);
    chk({30'h0, r}, {30'h0, csw_pkg::RESP_SLVERR});
    rchk(8'h0c, 32'h0, csw_pkg::RESP_SLVERR);
    sw(1'b1, rs, n);
    rng(rs, 7, 9);
    rchk(csw_pkg::STATUS_ADDR, 32'h1, csw_pkg::RESP_OKAY);
    rchk(csw_pkg::OSC_SEL_ADDR, 32'h1, csw_pkg::RESP_OKAY);
    sw(1'b0, rs, n);
    rng(rs, 7, 9);
    rchk(csw_pkg::STATUS_ADDR, 32'h0, csw_pkg::RESP_OKAY);
    sw(1'b1, rs, n);
    pulse(0);
    cyc(3);
    rchk(csw_pkg::OSC_SEL_ADDR, 32'h0, csw_pkg::RESP_OKAY);
    rchk(csw_pkg::STATUS_ADDR, 32'h0, csw_pkg::RESP_OKAY);
    // Brown-out restarts the power-up delay
    power_up_delay_timer_en <= 1'b1;
    bor <= 1'b1;
    cyc(20);
    chk({31'h0, hold}, 32'h1);
    bor <= 1'b0;
    wt(1, 1'b0, 2000, n);
    rng(n, PW, PW + 8);
    // Sleep in RC mode, woken by each source in turn
    for (int k = 0; k < 3; k++) begin
      wr(csw_pkg::CONTROL_ADDR, 32'h1, r);
      wt(2, 1'b1, 200, n);
      chk({29'h0, osc_en, pin_o, pin_oe_n}, 32'h0);
      pulse(k);
      wt(2, 1'b0, 4, n);
      chk({31'h0, stall}, 32'h0);
    end
    // IO variant keeps the port function through sleep
    pwr(3'h7, 1'b0, n, rs);
    pa_oe_n <= 1'b0;
    pa_out <= 1'b1;
    wr(csw_pkg::CONTROL_ADDR, 32'h1, r);
    wt(2, 1'b1, 200, n);
    cyc(4);
    chk({29'h0, pin_oe_n, pin_o, pa_in}, 32'h3);
    pa_oe_n <= 1'b1;
    pulse(2);
    wt(2, 1'b0, 4, n);
    // Crystal mode: start-up count after the power-up delay
    pwr(3'h1, 1'b1, n, rs);
    rng(rs, 1024, 1040);
    wr(csw_pkg::CONTROL_ADDR, 32'h1, r);
    wt(2, 1'b1, 200, n);
    chk({30'h0, fb_en, pin_oe_n}, 32'h1);
    r0 = main_r;
    pulse(2);
    wt(0, 1'b1, 4, n);
    wt(0, 1'b0, 20000, n);
    rng(main_r - r0, 1020, 1034);
    sw(1'b1, rs, n);
    sw(1'b0, rs, n);
    rng(rs, 1031, 1036);
    // Multiplier mode adds its lock time after the start-up count
    pwr(3'h6, 1'b1, n, rs);
    rng(rs, 1024, 1045);
    rng(n, PW + PL + 4600, 6000);
    rchk(csw_pkg::STATUS_ADDR, 32'h10, csw_pkg::RESP_OKAY);
    sw(1'b1, rs, n);
    sw(1'b0, rs, n);
    rng(n, PL + 4600, 6000);
    close_out;
  end
endmodule // csw_clock_switch_tb
`default_nettype wire

// ===== tb/csw_osc_model.sv
// Behavioural main and secondary oscillator sources
`timescale 1ns/10ps
`default_nettype none
module csw_osc_model #(
  parameter real MAIN_HALF = 11.3,
  parameter real SEC_HALF = 37.1
) (
  // Enable from the block
  input wire logic en,
  // Oscillator waveforms
  output logic main_pin,
  output logic sec_pin
);
  initial main_pin = 1'b0;
  initial sec_pin = 1'b0;
  // Main source stands low while switched off, as in sleep
  always #(MAIN_HALF) main_pin = en ? ~main_pin : 1'b0;
  // Secondary is assumed to run all the time
  always #(SEC_HALF) sec_pin = ~sec_pin;
endmodule // csw_osc_model
`default_nettype wire
